//--- mpf_pkg.sv
// constants, field layout and carrier types of the motor pwm output and fault block
// assumes a 32-bit apb bus, byte addresses, one register per aligned word
package mpf_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NCH  = 6;
  localparam int NGEN = 3;
  localparam int NFLT = 6;
  localparam int AW   = 8;
  localparam int NST  = 3;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] A_CFG1 = 8'h00;
  localparam logic [AW-1:0] A_CFG2 = 8'h04;
  localparam logic [AW-1:0] A_FEN  = 8'h08;
  localparam logic [AW-1:0] A_FMOD = 8'h0C;
  localparam logic [AW-1:0] A_ENC  = 8'h10;
  localparam logic [AW-1:0] A_OUTC = 8'h14;
  localparam logic [AW-1:0] A_OUTV = 8'h18;
  localparam logic [AW-1:0] A_MASK = 8'h1C;
  localparam logic [AW-1:0] A_STAT = 8'h20;
  localparam logic [AW-1:0] A_IMSK = 8'h24;

  // ---------------------------------------------------------------
  // field positions and write masks
  // ---------------------------------------------------------------
  localparam int F_WP   = 7;
  localparam int F_REV  = 6;
  localparam int F_FLVL = 0;
  localparam int F_CMPL = 1;
  localparam int F_CE   = 0;
  localparam int F_GLD  = 1;
  localparam int F_RST  = 4;
  localparam int F_LDOK = 7;
  localparam int ST_FLT  = 0;
  localparam int ST_COMM = 1;
  localparam int ST_REL  = 2;
  localparam logic [7:0] M_CFG1 = 8'hBF;
  localparam logic [7:0] M_FLT  = 8'h5F;
  localparam logic [1:0] REV_OFF = 2'h0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_CFG = 8'h00;
  localparam logic [9:0]  RST_ENC = 10'h000;
  localparam logic [31:0] RST_RD  = 32'h0000_0000;

  typedef enum logic [1:0] {
    AP_IDLE = 2'b01,
    AP_ACC  = 2'b10
  } mpf_ap_e;

  typedef struct packed {
    logic [NCH-1:0] outc;
    logic [NCH-1:0] outv;
    logic [NCH-1:0] mask;
  } mpf_buf_s;

  typedef struct packed {
    logic outc;
    logic outv;
    logic mask;
    logic dis;
    logic force_on;
    logic flvl;
    logic inv;
  } mpf_chan_ctrl_s;

  typedef struct packed {
    mpf_ap_e         ap;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic [7:0]      cfg1;
    logic [7:0]      cfg2;
    logic [7:0]      fen;
    logic [7:0]      fmod;
    logic [9:0]      enc;
    mpf_buf_s        sbuf;
    mpf_buf_s        act;
    logic [NFLT-1:0] flt;
    logic [NST-1:0]  stat;
    logic [NST-1:0]  imsk;
    logic            comm_q;
    logic [NCH-1:0]  chan_out;
    logic            reload_ev;
    logic [NGEN-1:0] gen_load;
    logic [NGEN-1:0] gen_restart;
    logic            irq;
  } mpf_state_s;

endpackage

//--- mpf_chan_out.sv
// one output channel: override, mask, fault gating and polarity
// purely combinational; the caller registers the result
`timescale 1ns/1ps

module mpf_chan_out
  import mpf_pkg::*;
(
  input  logic           raw,
  input  mpf_chan_ctrl_s ctrl,
  output logic           pin
);

  logic v;

  always_comb begin
    v = ctrl.outc ? ctrl.outv : raw;
    if (ctrl.mask) begin
      v = 1'b0;
    end
    if (ctrl.dis) begin
      v = 1'b0;
    end
    if (ctrl.force_on) begin
      v = ctrl.flvl;
    end
    pin = v ^ ctrl.inv;
  end

endmodule // mpf_chan_out

//--- mpf_top.sv
// output conditioning, fault protection and configuration of a six-channel pwm unit
// assumes generator counters and deadtime live outside; all inputs synchronous to pclk
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps

module mpf_top
  import mpf_pkg::*;
(
  input  logic            pclk,
  input  logic            presetn,
  input  logic            ce,
  input  logic            psel,
  input  logic            penable,
  input  logic            pwrite,
  input  logic [AW-1:0]   paddr,
  input  logic [31:0]     pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  input  logic [NCH-1:0]  gen_pwm,
  input  logic [NGEN-1:0] gen_reload,
  input  logic [NGEN-1:0] dead_time_active,
  input  logic [NGEN-1:0] current_status_inputs_n,
  input  logic [NFLT-1:0] fault_inputs,
  input  logic            global_load_ok,
  input  logic            commutation_event,
  output logic [NCH-1:0]  channel_outputs,
  output logic            reload_event_out,
  output logic [NGEN-1:0] gen_load_strobe,
  output logic [NGEN-1:0] gen_restart,
  output logic            irq
);

  mpf_state_s     s_r;
  mpf_state_s     s_nxt;
  logic           wr_acc;
  logic           rd_acc;
  logic           mapped;
  logic [31:0]    rdata;
  logic           wp;
  logic           comm_en;
  logic           comm_evt;
  logic [NGEN-1:0] ld_eff;
  logic [NCH-1:0]  raw_c;
  logic [NCH-1:0]  pin_c;
  logic [NFLT-1:0] fen6;
  logic [NFLT-1:0] fmod6;
  mpf_chan_ctrl_s  cc [NCH];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign wp       = s_r.cfg1[F_WP];
  assign comm_en  = s_r.enc[F_CE];
  assign wr_acc   = (s_r.ap == AP_ACC) && psel && penable && pwrite;
  assign rd_acc   = (s_r.ap == AP_ACC) && psel && penable && !pwrite;
  assign comm_evt = comm_en && commutation_event && !s_r.comm_q;
  assign fen6     = {s_r.fen[6], s_r.fen[4:0]};
  assign fmod6    = {s_r.fmod[6], s_r.fmod[4:0]};
  assign ld_eff   = (s_r.enc[F_GLD +: NGEN] & {NGEN{global_load_ok}})
                  | (~s_r.enc[F_GLD +: NGEN] & s_r.enc[F_LDOK +: NGEN]);

  always_comb begin
    mapped = 1'b1;
    rdata  = RST_RD;
    case (paddr)
      A_CFG1:  rdata[7:0] = s_r.cfg1;
      A_CFG2:  rdata[7:0] = s_r.cfg2;
      A_FEN:   rdata[7:0] = s_r.fen;
      A_FMOD:  rdata[7:0] = s_r.fmod;
      A_ENC:   rdata[9:0] = s_r.enc;
      A_OUTC:  rdata[NCH-1:0] = s_r.sbuf.outc;
      A_OUTV:  rdata[NCH-1:0] = s_r.sbuf.outv;
      A_MASK:  rdata[NCH-1:0] = s_r.sbuf.mask;
      A_STAT:  rdata[NST-1:0] = s_r.stat;
      A_IMSK:  rdata[NST-1:0] = s_r.imsk;
      default: mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // current status correction, one pair per step
  // ---------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NGEN; gp++) begin : g_pair
      logic corr;
      assign corr = s_r.cfg2[F_CMPL] && dead_time_active[gp];
      assign raw_c[2*gp]   = corr ? !current_status_inputs_n[gp]
                                  : gen_pwm[2*gp];
      assign raw_c[2*gp+1] = corr ? current_status_inputs_n[gp]
                                  : gen_pwm[2*gp+1];
    end
  endgenerate

  // ---------------------------------------------------------------
  // output channels
  // ---------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_chan
      always_comb begin
        cc[gc].outc     = s_r.act.outc[gc];
        cc[gc].outv     = s_r.act.outv[gc];
        cc[gc].mask     = s_r.act.mask[gc];
        cc[gc].dis      = |s_r.flt[3:0];
        cc[gc].force_on = |s_r.flt[5:4];
        cc[gc].flvl     = s_r.cfg2[F_FLVL];
        cc[gc].inv      = s_r.cfg1[gc];
      end
      mpf_chan_out u_chan (
        .raw  (raw_c[gc]),
        .ctrl (cc[gc]),
        .pin  (pin_c[gc])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // apb: zero wait, read data caught in the setup cycle
    case (s_r.ap)
      AP_IDLE: begin
        if (psel && !penable) begin
          s_nxt.ap      = AP_ACC;
          s_nxt.pready  = 1'b1;
          s_nxt.pslverr = !mapped;
          s_nxt.prdata  = rdata;
        end
      end
      AP_ACC: begin
        s_nxt.ap      = AP_IDLE;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
      end
      default: s_nxt.ap = AP_IDLE;
    endcase
    // hardware consumes local load-ok
    s_nxt.enc[F_LDOK +: NGEN] = s_r.enc[F_LDOK +: NGEN] & ~(gen_reload & ld_eff);
    if (wr_acc) begin
      case (paddr)
        A_CFG1: begin
          if (!wp) begin
            s_nxt.cfg1 = pwdata[7:0] & M_CFG1;
          end
          s_nxt.cfg1[F_WP] = wp | pwdata[F_WP];
        end
        A_CFG2: begin
          s_nxt.cfg2[5:0] = pwdata[5:0];
          if (!wp) begin
            s_nxt.cfg2[F_REV +: 2] = pwdata[F_REV +: 2];
          end
        end
        A_FEN: begin
          if (!wp) begin
            s_nxt.fen = pwdata[7:0] & M_FLT;
          end
        end
        A_FMOD:  s_nxt.fmod = pwdata[7:0] & M_FLT;
        A_ENC: begin
          s_nxt.enc[F_CE] = pwdata[F_CE];
          s_nxt.enc[F_LDOK +: NGEN] = pwdata[F_LDOK +: NGEN];
          if (!wp) begin
            s_nxt.enc[F_GLD +: NGEN] = pwdata[F_GLD +: NGEN];
            s_nxt.enc[F_RST +: NGEN] = pwdata[F_RST +: NGEN];
          end
        end
        A_OUTC:  s_nxt.sbuf.outc = pwdata[NCH-1:0];
        A_OUTV:  s_nxt.sbuf.outv = pwdata[NCH-1:0];
        A_MASK:  s_nxt.sbuf.mask = pwdata[NCH-1:0];
        A_IMSK:  s_nxt.imsk = pwdata[NST-1:0];
        default: s_nxt.pslverr = 1'b0;
      endcase
    end
    // buffered copies move only on the event when commutation is on
    if (!comm_en || comm_evt) begin
      s_nxt.act = s_nxt.sbuf;
    end
    s_nxt.comm_q      = commutation_event;
    s_nxt.gen_restart = comm_evt ? s_r.enc[F_RST +: NGEN]
                                 : {NGEN{1'b0}};
    s_nxt.gen_load    = gen_reload & ld_eff;
    s_nxt.reload_ev   = (s_r.cfg2[F_REV +: 2] != REV_OFF)
                      && gen_reload[s_r.cfg2[F_REV +: 2] - 2'd1];
    // faults: manual recovery waits for a status read
    for (int i = 0; i < NFLT; i++) begin
      if (!fault_inputs[i] && (fmod6[i] || (rd_acc && paddr == A_STAT))) begin
        s_nxt.flt[i] = 1'b0;
      end
      if (fen6[i] && fault_inputs[i]) begin
        s_nxt.flt[i] = 1'b1;
      end
    end
    // status: read clears only what was shown, a new event wins
    if (rd_acc && paddr == A_STAT) begin
      s_nxt.stat = s_r.stat & ~s_r.prdata[NST-1:0];
    end
    if (|(s_nxt.flt & ~s_r.flt)) begin
      s_nxt.stat[ST_FLT] = 1'b1;
    end
    if (comm_evt) begin
      s_nxt.stat[ST_COMM] = 1'b1;
    end
    if (s_nxt.reload_ev) begin
      s_nxt.stat[ST_REL] = 1'b1;
    end
    s_nxt.irq      = |(s_nxt.stat & s_nxt.imsk);
    s_nxt.chan_out = pin_c;
  end

  // ---------------------------------------------------------------
  // state register, frozen while ce is low
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r             <= '0;
      s_r.ap          <= AP_IDLE;
      s_r.cfg1        <= RST_CFG;
      s_r.cfg2        <= RST_CFG;
      s_r.fen         <= RST_CFG;
      s_r.fmod        <= RST_CFG;
      s_r.enc         <= RST_ENC;
      s_r.prdata      <= RST_RD;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign prdata           = s_r.prdata;
  assign pready           = s_r.pready;
  assign pslverr          = s_r.pslverr;
  assign channel_outputs  = s_r.chan_out;
  assign reload_event_out = s_r.reload_ev;
  assign gen_load_strobe  = s_r.gen_load;
  assign gen_restart      = s_r.gen_restart;
  assign irq              = s_r.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wp_sticky;
    wp |=> wp;
  endproperty
  a_wp_sticky: assert property (p_wp_sticky) else $error("write protect dropped");

  property p_pol_locked;
    ce && wr_acc && paddr == A_CFG1 && wp |=> $stable(s_r.cfg1[NCH-1:0]);
  endproperty
  a_pol_locked: assert property (p_pol_locked) else $error("polarity moved");

  property p_cfg2_write;
    ce && wr_acc && paddr == A_CFG2 && wp
      |=> $stable(s_r.cfg2[7:6]) && s_r.cfg2[5:0] == $past(pwdata[5:0]);
  endproperty
  a_cfg2_write: assert property (p_cfg2_write) else $error("cfg2 write wrong");

  property p_fen_locked;
    ce && wr_acc && paddr == A_FEN && wp |=> $stable(s_r.fen);
  endproperty
  a_fen_locked: assert property (p_fen_locked) else $error("fault enable moved");

  property p_fmod_write;
    ce && wr_acc && paddr == A_FMOD |=> s_r.fmod == ($past(pwdata[7:0]) & M_FLT);
  endproperty
  a_fmod_write: assert property (p_fmod_write) else $error("fault mode not written");

  property p_comm_off;
    ce && !comm_en |=> gen_restart == '0;
  endproperty
  a_comm_off: assert property (p_comm_off) else $error("restart without commutation");

  property p_buffered;
    ce && comm_en && !comm_evt |=> $stable(s_r.act);
  endproperty
  a_buffered: assert property (p_buffered) else $error("buffer moved early");

  property p_restart;
    ce && comm_evt |=> gen_restart == $past(s_r.enc[F_RST +: NGEN]);
  endproperty
  a_restart: assert property (p_restart) else $error("restart mismatch");

  property p_gload;
    ce && global_load_ok && (gen_reload & s_r.enc[F_GLD +: NGEN]) != '0
      |=> (gen_load_strobe & $past(s_r.enc[F_GLD +: NGEN]))
          == $past(gen_reload & s_r.enc[F_GLD +: NGEN]);
  endproperty
  a_gload: assert property (p_gload) else $error("global load ignored");

  property p_rev_off;
    ce && s_r.cfg2[F_REV +: 2] == REV_OFF |=> !reload_event_out;
  endproperty
  a_rev_off: assert property (p_rev_off) else $error("reload output while off");

  property p_fault_dis;
    ce && |s_r.flt[3:0] && !(|s_r.flt[5:4])
      |=> channel_outputs == $past(s_r.cfg1[NCH-1:0]);
  endproperty
  a_fault_dis: assert property (p_fault_dis) else $error("fault did not disable");

  c_comm: cover property (ce && comm_evt ##1 gen_restart != '0);
  c_fault: cover property (ce && |s_r.flt[5:4]);
  c_irq: cover property (irq ##[1:20] !irq);

endmodule // mpf_top

//--- mpf_stage_model.sv
// power stage seen from the channel outputs: fault lines and current sense
// assumes the bench requests faults; everything is sampled on pclk
`timescale 1ns/1ps

module mpf_stage_model
  import mpf_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic [NCH-1:0]  channel_outputs,
  input  wire logic [NFLT-1:0] fault_req,
  output logic      [NFLT-1:0] fault_inputs,
  output logic      [NGEN-1:0] current_status_inputs_n
);
  // ---------------------------------------------------------------
  // fault lines and current sense
  // ---------------------------------------------------------------
  // one flop of delay, as a real comparator would add
  always_ff @(posedge pclk) begin
    fault_inputs <= fault_req;
    for (int p = 0; p < NGEN; p++) begin
      current_status_inputs_n[p] <= ~channel_outputs[2*p];
    end
  end
endmodule // mpf_stage_model

//--- tb_motor_pwm_fault_config.sv
// self-checking bench: apb stimulus, stage model, reference model
// assumes apb answers within 64 cycles and one-cycle output latency
`timescale 1ns/1ps

module tb_motor_pwm_fault_config;
  import mpf_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] gen_pwm, fault_inputs, fault_req, channel_outputs;
  logic [2:0] gen_reload, dead_time_active, cs_n, gen_load_strobe, gen_restart;
  logic global_load_ok, commutation_event, reload_event_out, irq, glok;
  int seed, fail_count, n_checks;
  logic [5:0] pol, c2lo, msk, mbuf, oc, ocb, ov, ovb;
  logic [7:0] fen, fmod, v8;
  logic [9:0] enc;
  logic [1:0] rev;
  logic wp, err;
  logic [31:0] v;
  logic [7:0] adrs[6] = '{A_CFG1, A_CFG2, A_FEN, A_FMOD, A_ENC, 8'h28};
  int ks[3] = '{0, 1, 4};

  always #12.5 pclk = ~pclk;

  mpf_top u_mpf_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gen_pwm(gen_pwm),
    .gen_reload(gen_reload), .dead_time_active(dead_time_active),
    .current_status_inputs_n(cs_n), .fault_inputs(fault_inputs),
    .global_load_ok(global_load_ok), .commutation_event(commutation_event),
    .channel_outputs(channel_outputs), .reload_event_out(reload_event_out),
    .gen_load_strobe(gen_load_strobe), .gen_restart(gen_restart), .irq(irq));

  mpf_stage_model u_mpf_stage_model (.pclk(pclk), .channel_outputs(channel_outputs),
    .fault_req(fault_req), .fault_inputs(fault_inputs),
    .current_status_inputs_n(cs_n));

  // ---------------------------------------------------------------
  // checking and verdict
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      A_CFG1: return {24'h00_0000, wp, 1'b0, pol};
      A_CFG2: return {24'h00_0000, rev, c2lo};
      A_FEN:  return {24'h00_0000, fen};
      A_FMOD: return {24'h00_0000, fmod};
      A_ENC:  return {22'h00_0000, enc};
      default: return 32'h0000_0000;
    endcase
  endfunction

  // fault 4-5 override after 0-3, polarity last
  function automatic logic [5:0] eo(input logic [5:0] raw);
    logic [5:0] o;
    logic [5:0] fl;
    fl = fault_req & {fen[6], fen[4:0]};
    o = ((raw & ~oc) | (ov & oc)) & ~msk;
    if (|fl[3:0]) o = 6'h00;
    if (|fl[5:4]) o = {6{c2lo[0]}};
    return o ^ pol;
  endfunction

  // ---------------------------------------------------------------
  // apb master and drivers
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // answer read at the rising edge that ends the access, before it updates
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      fail_count++;
      wrap_up;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    case (a)
      A_CFG1: begin
        if (!wp) pol = d[5:0];
        wp = wp | d[7];
      end
      A_CFG2: begin
        c2lo = d[5:0];
        if (!wp) rev = d[7:6];
      end
      A_FEN: if (!wp) fen = d[7:0] & M_FLT;
      A_FMOD: fmod = d[7:0] & M_FLT;
      A_ENC: enc = wp ? {d[9:7], enc[6:1], d[0]} : d[9:0];
      A_OUTC: ocb = d[5:0];
      A_OUTV: ovb = d[5:0];
      A_MASK: mbuf = d[5:0];
      default: ;
    endcase
    if (!enc[0]) begin
      msk = mbuf;
      oc = ocb;
      ov = ovb;
    end
  endtask

  task automatic rd_all;
    logic [31:0] r;
    logic e;
    foreach (adrs[i]) begin
      apb(1'b0, adrs[i], 32'h0000_0000, r, e);
      chk(r, exp_rd(adrs[i]));
      chk(e, adrs[i] == 8'h28);
    end
  endtask

  task automatic chk_out(input int n);
    repeat (n) begin
      @(posedge pclk);
      gen_pwm <= $random(seed);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk(channel_outputs, eo(gen_pwm));
    end
  endtask

  // current sense during deadtime: top follows the inverse, bottom the level
  task automatic chk_cs;
    logic [2:0] c;
    @(negedge pclk);
    c = cs_n;
    @(negedge pclk);
    for (int p = 0; p < 3; p++) begin
      chk(channel_outputs[2*p +: 2], {c[p], ~c[p]} ^ pol[2*p +: 2]);
    end
  endtask

  task automatic rl(input int g);
    logic ld;
    glok = $random(seed);
    ld = enc[g+1] ? glok : enc[g+7];
    @(posedge pclk);
    gen_reload <= 3'h1 << g;
    global_load_ok <= glok;
    @(posedge pclk);
    gen_reload <= 3'h0;
    @(negedge pclk);
    chk(reload_event_out, rev == g + 1);
    chk(gen_load_strobe, {2'b00, ld} << g);
    if (ld) enc[g+7] = 1'b0;
  endtask

  task automatic ev;
    @(posedge pclk);
    commutation_event <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk(gen_restart, enc[0] ? enc[6:4] : 3'h0);
    @(posedge pclk);
    commutation_event <= 1'b0;
    if (enc[0]) begin
      msk = mbuf;
      oc = ocb;
      ov = ovb;
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 61869;
    {fail_count, n_checks} = '0;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {gen_pwm, gen_reload, fault_req, global_load_ok, commutation_event} = '0;
    {pol, c2lo, msk, mbuf, oc, ocb, ov, ovb, fen, fmod, enc, rev, wp} = '0;
    ce = 1'b1;
    dead_time_active = 3'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_all;
    wr(A_CFG1, $random(seed) & 8'h3F);
    chk_out(4);
    // clock enable low must freeze the outputs
    @(posedge pclk);
    ce <= 1'b0;
    v8 = {2'b00, channel_outputs};
    gen_pwm <= ~gen_pwm;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(channel_outputs, v8[5:0]);
    @(posedge pclk);
    ce <= 1'b1;
    wr(A_OUTV, $random(seed));
    wr(A_OUTC, $random(seed));
    chk_out(2);
    wr(A_OUTC, 32'h0000_0000);
    wr(A_CFG2, 8'h02);
    dead_time_active <= 3'h7;
    repeat (2) chk_cs;
    @(posedge pclk);
    dead_time_active <= 3'h0;
    wr(A_ENC, 10'h38A);
    for (int r = 0; r < 4; r++) begin
      wr(A_CFG2, r << 6);
      for (int g = 0; g < 3; g++) rl(g);
    end
    wr(A_CFG2, 8'h01);
    wr(A_FEN, 8'h11);
    wr(A_FMOD, 8'h11);
    foreach (ks[i]) begin
      @(posedge pclk);
      fault_req <= 6'h01 << ks[i];
      chk_out(2);
      @(posedge pclk);
      fault_req <= 6'h00;
      repeat (4) @(posedge pclk);
      chk_out(1);
    end
    wr(A_ENC, 10'h07A);
    ev();
    wr(A_ENC, 10'h07B);
    wr(A_MASK, 8'h3F);
    chk_out(2);
    ev();
    @(negedge pclk);
    chk(irq, 1'b0);
    chk_out(1);
    wr(A_IMSK, 8'h02);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(irq, 1'b1);
    apb(1'b0, A_STAT, 32'h0000_0000, v, err);
    chk(v, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(irq, 1'b0);
    // lock, then try to move every protected field
    wr(A_CFG1, 8'h80);
    wr(A_CFG1, $random(seed) & 8'h3F);
    v8 = $random(seed);
    wr(A_CFG2, v8);
    wr(A_FEN, $random(seed));
    wr(A_FMOD, $random(seed));
    wr(A_ENC, $random(seed) & 10'h07F);
    rd_all;
    chk_out(2);
    wrap_up;
  end

  // bench needs roughly 300 cycles; far more means a hang
  initial begin
    #(25 * 20000);
    fail_count++;
    wrap_up;
  end
endmodule // tb_motor_pwm_fault_config
